// ===== rtl/universal_serial_shift_unit.sv
// Serial shift unit: 8-bit shift register, 4-bit edge counter, clock select
`timescale 1ns/1ps
`include "ussu_consts.svh"

module universal_serial_shift_unit
    import ussu_pkg::*;
(
    input  wire logic                    clk,             // System clock 250 MHz
    input  wire logic                    resetn,          // Async reset, active low
    input  wire logic [1:0]              wireModeSelect,  // Off, three-wire, two-wire
    input  wire logic [1:0]              clockSourceSelect, // None, timer, pin
    input  wire logic                    clockEdgeSelect, // Sampling edge choice
    input  wire logic                    swClockStrobe,   // Software clock strobe pulse
    input  wire logic                    toggleStrobe,    // Clock pin toggle pulse
    input  wire logic                    timerZeroOverflow, // Timer overflow pulse
    input  wire logic                    dataWrite,       // Load shift register
    input  wire logic [`USSU_DATA_W-1:0] dataIn,          // Value to load
    input  wire logic                    countWrite,      // Load counter
    input  wire logic [`USSU_CNT_W-1:0]  countIn,         // Counter value to load
    input  wire logic                    ovfClear,        // Clear flag (counter on countWrite)
    input  wire logic                    startClear,      // Clear start flag
    input  wire logic                    holdOnOverflow,  // Hold clock after overflow, two-wire mode only
    input  wire logic                    serialInputPin,  // Data in from pin
    input  wire logic                    serialClockPin,  // Clock level at pin
    input  wire logic                    sdaIn,           // Two-wire data level
    output logic [`USSU_DATA_W-1:0]      serialShiftReg,  // Shift register contents
    output logic [`USSU_CNT_W-1:0]       counterValue,    // Counter contents
    output logic                         overflowFlag,    // Sticky overflow request
    output logic                         startFlag,       // Sticky start request
    output logic                         dataOutPin,      // Three-wire data out
    output logic                         sdaOut,          // Two-wire data out level
    output logic                         clockOut,        // Clock pin output level
    output logic                         clockHoldLow     // Holding clock pin low
);

    //--------------------------------------------------------------
    // State registers
    //--------------------------------------------------------------
    ussu_state_t stateFf;     // Registered state
    ussu_state_t nxtState;    // Next state
    logic        rstnInt;     // Synchronised reset

    // Reset copy comes from the standalone chain, never from the state
    // it resets: a self-reset copy would never leave reset again
    assign rstnInt = rstSyncFf[1];

    //--------------------------------------------------------------
    // Operating notes
    //--------------------------------------------------------------
    // Clocking
    //   The serial clock pin is asynchronous to clk. It passes two
    //   flops and a third flop gives the previous level, so a pin
    //   edge turns into a one-cycle rise or fall event about three
    //   system clocks after it happens at the pin.
    //   The data input pin passes the same two flops, so data and
    //   clock events stay aligned through the synchronisers.
    // Sampling and shifting
    //   On every sampling event the register moves one place towards
    //   the top and the synced input bit enters at the bottom.
    //   Eight sampling events therefore bring in a whole byte, most
    //   significant bit first, while the old top bit drops out each time.
    // Output latch
    //   The latch takes the register's top bit only on the output
    //   edge (or on a CPU load), so the data output stays put from
    //   the sampling edge until the opposite edge.
    //   With the software or timer source both edges collapse into
    //   one event and the latch is simply transparent.
    // Counter
    //   The counter advances together with the shifter. With the
    //   pin source it counts edges, so sixteen edges make one byte.
    //   Overflow wraps to zero and sets the sticky flag; a set in
    //   the same cycle as a clear wins.
    // Limits
    //   The pin clock half period must span at least four system
    //   clocks, or edges merge in the synchroniser and are lost.
    //   The shift register has no receive buffer: software must
    //   read it before the next transfer starts.
    // Two-wire control
    //   Only start detection and clock stretching are present. The
    //   stretch releases once software clears the start flag, or
    //   the overflow flag when holding after overflow is enabled.

    //--------------------------------------------------------------
    // Reset release synchroniser
    //--------------------------------------------------------------
    logic [1:0] rstSyncFf;    // Reset release chain
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstSyncFf <= 2'h0;
        end else begin
            rstSyncFf <= {rstSyncFf[0], 1'b1};
        end
    end

    //--------------------------------------------------------------
    // Next-state logic
    //--------------------------------------------------------------
    logic ckRise;     // Synced pin clock rising
    logic ckFall;     // Synced pin clock falling
    logic extMode;    // Pin clock selected
    logic sampleEv;   // Sample data input now
    logic shiftEv;    // Advance output latch now
    logic cntEv;      // Advance counter now
    logic diBit;      // Synced data input
    logic sdaNow;     // Synced two-wire data
    logic sclNow;     // Synced clock level
    logic [`USSU_CNT_W-1:0] cntBase; // Counter after any write
    logic ovfNow;     // Counter wraps this cycle

    always_comb begin
        nxtState = stateFf;
        nxtState.rstSync = rstSyncFf;
        // Two-flop synchronisers for pins
        nxtState.ckSync  = {stateFf.ckSync[1:0], serialClockPin};
        nxtState.diSync  = {stateFf.diSync[0], serialInputPin};
        nxtState.sdaSync = {stateFf.sdaSync[0], sdaIn};
        ckRise  = stateFf.ckSync[1] & ~stateFf.ckSync[2];
        ckFall  = ~stateFf.ckSync[1] & stateFf.ckSync[2];
        sclNow  = stateFf.ckSync[1];
        diBit   = stateFf.diSync[1];
        sdaNow  = stateFf.sdaSync[1];
        nxtState.sdaPrev = sdaNow;
        extMode = (clockSourceSelect == `USSU_CS_EXT);
        sampleEv = 1'b0;
        shiftEv  = 1'b0;
        cntEv    = 1'b0;
        case (clockSourceSelect)
            `USSU_CS_EXT: begin
                // clear selects rising sample, falling shift
                // set selects falling sample, rising shift
                sampleEv = clockEdgeSelect ? ckFall : ckRise;
                shiftEv  = clockEdgeSelect ? ckRise : ckFall;
                cntEv    = ckRise | ckFall;
            end
            `USSU_CS_TIMER: begin
                sampleEv = timerZeroOverflow;
                shiftEv  = timerZeroOverflow;
                cntEv    = timerZeroOverflow;
            end
            default: begin
                // software strobe shifts and counts; toggle never counts here
                sampleEv = swClockStrobe;
                shiftEv  = swClockStrobe;
                cntEv    = swClockStrobe | (extMode & toggleStrobe);
            end
        endcase
        if (dataWrite) begin
            // Load wins over a shift in the same cycle
            nxtState.shiftReg = dataIn;
        end else if (sampleEv) begin
            // sampled bit enters, top bit moves out
            nxtState.shiftReg = {stateFf.shiftReg[`USSU_DATA_W-2:0], diBit};
        end
        // latch passes on output edge, or always without pin clock
        // A load also opens it, so the first bit stands before sampling
        if (dataWrite || shiftEv || !extMode) begin
            nxtState.outLatch = nxtState.shiftReg[`USSU_DATA_W-1];
        end
        cntBase = countWrite ? countIn : stateFf.bitCount;
        ovfNow = cntEv && (cntBase == `USSU_CNT_MAX);
        nxtState.bitCount = cntEv ? cntBase + 4'h1 : cntBase;
        // overflow sets flag, set beats clear
        // flag level serves as idle wake request
        nxtState.ovfFlag = ovfNow | (stateFf.ovfFlag & ~ovfClear);
        nxtState.doPin  = (wireModeSelect == `USSU_WM_THREE) ? stateFf.outLatch
                                                              : stateFf.doPin;
        nxtState.sdaPin = (wireModeSelect == `USSU_WM_TWO) ? stateFf.outLatch
                                                            : 1'b1;
        if (toggleStrobe) begin
            nxtState.ckOut = ~stateFf.ckOut;
        end
        // start detect, SDA falls with SCL high
        case (stateFf.twState)
            USSU_TW_IDLE: begin
                if ((wireModeSelect == `USSU_WM_TWO) && sclNow &&
                    stateFf.sdaPrev && !sdaNow) begin
                    nxtState.twState = USSU_TW_START;
                end
            end
            USSU_TW_START: begin
                // hold after start until SCL low and cleared
                if (!sclNow) begin
                    nxtState.twState = USSU_TW_HOLD;
                end
            end
            USSU_TW_HOLD: begin
                if (!stateFf.startFlag) begin
                    nxtState.twState = USSU_TW_IDLE;
                end
            end
            default: nxtState.twState = USSU_TW_IDLE;
        endcase
        nxtState.startFlag = (stateFf.twState == USSU_TW_IDLE && nxtState.twState ==
                              USSU_TW_START) | (stateFf.startFlag & ~startClear);
        nxtState.sclHold = (wireModeSelect == `USSU_WM_TWO) &&
                           ((stateFf.twState == USSU_TW_HOLD && stateFf.startFlag) ||
                            (holdOnOverflow && nxtState.ovfFlag));
    end

    //--------------------------------------------------------------
    // State register
    //--------------------------------------------------------------
    always_ff @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            stateFf <= '{rstSync: 2'h0, ckSync: 3'h0, diSync: 2'h0, sdaSync: 2'h3,
                         sdaPrev: 1'b1, shiftReg: `USSU_DATA_RST, bitCount: `USSU_CNT_RST,
                         outLatch: 1'b0, ovfFlag: 1'b0, startFlag: 1'b0, ckOut: 1'b0,
                         doPin: 1'b0, sdaPin: 1'b1, sclHold: 1'b0, twState: USSU_TW_IDLE};
        end else begin
            stateFf <= nxtState;
        end
    end

    //--------------------------------------------------------------
    // Outputs from flops; clockOut gated by sclHold
    //--------------------------------------------------------------
    assign serialShiftReg = stateFf.shiftReg;
    assign counterValue   = stateFf.bitCount;
    assign overflowFlag   = stateFf.ovfFlag;
    assign startFlag      = stateFf.startFlag;
    assign dataOutPin     = stateFf.doPin;
    assign sdaOut         = stateFf.sdaPin;
    assign clockOut       = stateFf.ckOut & ~stateFf.sclHold;
    assign clockHoldLow   = stateFf.sclHold;

    // software loads data and clears counter before transfer
    // partner keeps external clock within limits
endmodule

// ===== rtl/ussu_consts.svh
// Constants for the three-wire and two-wire serial shift unit
`ifndef USSU_CONSTS_SVH
`define USSU_CONSTS_SVH
`define USSU_DATA_W       8
`define USSU_CNT_W        4
`define USSU_DATA_RST     8'h00
`define USSU_CNT_RST      4'h0
`define USSU_CNT_MAX      4'hf
`define USSU_WM_OFF       2'h0
`define USSU_WM_THREE     2'h1
`define USSU_WM_TWO       2'h2
`define USSU_CS_NONE      2'h0
`define USSU_CS_TIMER     2'h1
`define USSU_CS_EXT       2'h2
`endif

// ===== rtl/ussu_pkg.sv
// Types for the three-wire and two-wire serial shift unit
package ussu_pkg;
    `include "ussu_consts.svh"
    // Two-wire start detector phase
    typedef enum logic [1:0] {
        USSU_TW_IDLE,
        USSU_TW_START,
        USSU_TW_HOLD
    } ussu_tw_t;
    // Complete state of the unit
    typedef struct packed {
        logic [1:0]            rstSync;
        logic [2:0]            ckSync;
        logic [1:0]            diSync;
        logic [1:0]            sdaSync;
        logic                  sdaPrev;
        logic [`USSU_DATA_W-1:0] shiftReg;
        logic [`USSU_CNT_W-1:0]  bitCount;
        logic                  outLatch;
        logic                  ovfFlag;
        logic                  startFlag;
        logic                  ckOut;
        logic                  doPin;
        logic                  sdaPin;
        logic                  sclHold;
        ussu_tw_t              twState;
    } ussu_state_t;
endpackage

// ===== dv/ussu_monitor.sv
// Port assertions for the serial shift unit
`timescale 1ns/1ps
module ussu_monitor (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [1:0] wireModeSelect,
    input wire logic [1:0] clockSourceSelect,
    input wire logic       swClockStrobe,
    input wire logic       toggleStrobe,
    input wire logic       timerZeroOverflow,
    input wire logic       dataWrite,
    input wire logic [7:0] dataIn,
    input wire logic       countWrite,
    input wire logic [3:0] countIn,
    input wire logic       ovfClear,
    input wire logic [7:0] serialShiftReg,
    input wire logic [3:0] counterValue,
    input wire logic       overflowFlag,
    input wire logic       clockOut
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire swStep = swClockStrobe && clockSourceSelect == 2'h0 && wireModeSelect == 2'h1
        && !countWrite && !ovfClear;
    a_data_load: assert property (dataWrite |=> serialShiftReg == $past(dataIn))
        else $error("shift register load lost");
    a_count_load: assert property (countWrite && !swClockStrobe && !timerZeroOverflow
        && clockSourceSelect != 2'h2
        |=> counterValue == $past(countIn)) else $error("counter load lost");
    a_sw_count: assert property (swStep |=> counterValue == $past(counterValue) + 4'h1)
        else $error("software step did not count");
    a_sw_shift: assert property (swStep && !dataWrite
        |=> serialShiftReg[7:1] == $past(serialShiftReg[6:0])) else $error("step did not shift");
    a_tmr_count: assert property (timerZeroOverflow && clockSourceSelect == 2'h1 && !countWrite
        |=> counterValue == $past(counterValue) + 4'h1) else $error("timer step did not count");
    a_ovf_wrap: assert property (swStep && counterValue == 4'hf
        |=> overflowFlag && counterValue == 4'h0) else $error("no overflow at wrap");
    a_ovf_clear: assert property (ovfClear && countWrite && countIn == 4'h0 && !swClockStrobe
        && !timerZeroOverflow && clockSourceSelect != 2'h2
        |=> !overflowFlag && counterValue == 4'h0) else $error("overflow clear failed");
    a_clk_toggle: assert property (toggleStrobe && wireModeSelect == 2'h1
        |=> clockOut != $past(clockOut)) else $error("clock pin did not toggle");
endmodule
bind universal_serial_shift_unit ussu_monitor i_mon (.*);

// ===== dv/ussu_spi_peer.sv
// Remote SPI master model facing the three-wire pins
`timescale 1ns/1ps
module ussu_spi_peer (
    output logic      sck = 1'b0,   // Serial clock, still low between frames
    output logic      mosi = 1'b1,  // Data towards the unit
    input  wire logic miso          // Data from the unit
);
    logic [7:0] got = 8'h00;        // Bits collected from the unit
    // Send n pulses, half period hns ns
    task automatic xfer(input logic [7:0] tx, input int n, input logic m1, input int hns);
        for (int i = 0; i < n; i++) begin
            mosi = m1 ? mosi : tx[7 - i];
            #hns sck = 1'b1;
            {mosi, got} = m1 ? {tx[7 - i], got} : {mosi, got[6:0], miso};
            #hns sck = 1'b0;
            got = m1 ? {got[6:0], miso} : got;
        end
        // Released line shows the inverse of its last bit
        #hns mosi = ~mosi;
    endtask
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the serial shift unit
`timescale 1ns/1ps
module tb_top;
    logic       clk = 1'b0, resetn = 1'b0;
    logic [1:0] wireModeSelect = 2'h1;        // Three-wire mode
    logic [1:0] clockSourceSelect = 2'h0;     // Software strobe
    logic       clockEdgeSelect = 1'b0;
    logic       swClockStrobe = 1'b0, toggleStrobe = 1'b0, timerZeroOverflow = 1'b0;
    logic       dataWrite = 1'b0, countWrite = 1'b0, ovfClear = 1'b0, startClear = 1'b0;
    logic [7:0] dataIn = 8'h00, serialShiftReg;
    logic [3:0] countIn = 4'h0, counterValue;
    logic       holdOnOverflow = 1'b0, sdaIn = 1'b1;    // Two-wire side held idle
    wire        serialInputPin, serialClockPin;
    logic       overflowFlag, startFlag, dataOutPin, sdaOut, clockOut, clockHoldLow;
    int         mismatches = 0, total_checks = 0;
    always #2 clk = ~clk;
    universal_serial_shift_unit i_dut (.*);
    ussu_spi_peer i_peer (.sck(serialClockPin), .mosi(serialInputPin), .miso(dataOutPin));
    // Compare seen against expected
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        mismatches += (seen !== exp);
        if (seen !== exp) $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    endtask
    // Let n edges pass, then step off the edge
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One-cycle strobe pulse: sw, toggle, timer, data, count, ovf clr, start clr
    task automatic pulse(input logic [6:0] m);
        @(posedge clk) {startClear, ovfClear, countWrite, dataWrite, timerZeroOverflow,
            toggleStrobe, swClockStrobe} <= m;
        @(posedge clk) {startClear, ovfClear, countWrite, dataWrite, timerZeroOverflow,
            toggleStrobe, swClockStrobe} <= 7'h00;
        settle(2);
    endtask
    // Verdict and end of run
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        settle(4);
        check({counterValue, overflowFlag, dataOutPin, clockOut, sdaOut}, 8'h01);
        dataIn <= 8'ha5;
        countIn <= 4'hd;
        pulse(7'h18);
        repeat (3) pulse(7'h01);
        check({overflowFlag, counterValue}, 8'h10);
        check(serialShiftReg[7:3], 8'h05);
        countIn <= 4'h0;
        pulse(7'h30);
        check({overflowFlag, counterValue}, 8'h00);
        clockSourceSelect <= 2'h1;
        repeat (2) pulse(7'h04);
        check(counterValue, 8'h02);
        pulse(7'h02);
        check(clockOut, 8'h01);
        clockSourceSelect <= 2'h2;
        // Pin-clocked exchanges: mode 0, mode 1, slow mode 0
        for (int e = 0; e < 3; e++) begin
            clockEdgeSelect <= (e == 1);
            dataIn <= 8'h3c ^ 8'(e);
            pulse(7'h38);
            i_peer.xfer(8'hc5 + 8'(e), 8, e == 1, 32 + 16 * (e / 2));
            settle(8);
            check(serialShiftReg, 8'hc5 + 8'(e));
            check({overflowFlag, counterValue}, 8'h10);
            if (e != 1) check(i_peer.got, 8'h3c ^ 8'(e));
        end
        summarize();
    end
    // Watchdog against a hang
    initial begin
        #100000 mismatches++;
        summarize();
    end
endmodule
